//--- rtl/pues_sequencer.sv
// pues_sequencer: enable, rail lockout and input lockout sequencing.
// assumes analog comparators deliver asynchronous level pins.
// Contract
// - attention low once enabled and rail good, after startup count
// - converter off while input below lockout
// - four-bit level, 4.5V to 8.5V, 0.4V steps
// - level resets 4.5V, rewritable except while off
// - 150us blanking before input lockout acts
// - enable pin starts sequence, low means off
// - power up needs rail good and enable
// - shut down on rail low or enable low
// - external supply select resets 0, 1 disables regulator
// - phy present only in full variant
`timescale 1ns/1ns
module pues_sequencer #(
    parameter bit FULL_VARIANT = 1'b1,
    parameter int unsigned BLANK_COUNT = pues_pkg::BLANK_CYC,
    parameter int unsigned START_COUNT = pues_pkg::START_CYC
) (
    // clocking
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    // pins from analog comparators
    input wire logic high_voltage_enable_pin,
    input wire logic rail_above_rise,
    input wire logic rail_above_fall,
    input wire logic input_above_level,
    // host configuration
    input wire pues_pkg::pues_cfg_t cfg,
    input wire logic conv_request,
    // outputs
    output logic attention_n_o,
    output logic attention_n_oe,
    output logic converter_enable,
    output logic internal_regulator_on,
    output logic phy_enable,
    output logic phy_reference_supply_on,
    output logic [pues_pkg::MV_W-1:0] input_undervoltage_level_mv,
    output pues_pkg::pues_stat_t status
);
    import pues_pkg::*;

    logic [3:0] pins;
    logic en_s, rise_s, fall_s, inok_s;

    pues_sync #(.WIDTH(4)) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .pin_in({high_voltage_enable_pin, rail_above_rise, rail_above_fall,
            input_above_level}),
        .level_out(pins)
    );
    assign {en_s, rise_s, fall_s, inok_s} = pins;

    pues_state_t st_reg, st_next;
    logic [BLANK_W-1:0] cnt_reg, cnt_next;
    logic in_low_reg, in_low_next;
    logic [BLANK_W-1:0] blank_reg, blank_next;
    logic [LEVEL_W-1:0] level_reg, level_next;
    logic ext_reg, ext_next;

    // power sequence
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        unique case (st_reg)
            PUES_OFF: begin
                cnt_next = '0;
                if (en_s && rise_s) begin
                    st_next = PUES_START;
                end
            end
            PUES_START: begin
                if (!en_s || !fall_s) begin
                    st_next = PUES_OFF;
                end else if (cnt_reg == BLANK_W'(START_COUNT - 1)) begin
                    st_next = PUES_ON;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            PUES_ON: begin
                if (!en_s || !fall_s) begin
                    st_next = PUES_OFF;
                end
            end
            default: st_next = PUES_OFF;
        endcase
    end

    // input lockout with blanking
    always_comb begin
        in_low_next = in_low_reg;
        blank_next = '0;
        if (st_reg == PUES_OFF) begin
            in_low_next = 1'b0;
        end else if (inok_s) begin
            in_low_next = 1'b0;
        end else if (!in_low_reg) begin
            if (blank_reg == BLANK_W'(BLANK_COUNT - 1)) begin
                in_low_next = 1'b1;
            end else begin
                blank_next = blank_reg + 1'b1;
            end
        end
    end

    // host configuration
    always_comb begin
        level_next = level_reg;
        ext_next = ext_reg;
        if (st_reg == PUES_OFF) begin
            level_next = LEVEL_RESET;
            ext_next = EXT_SEL_RESET;
        end else begin
            if (cfg.level_we) begin
                // codes above the top step clamp at the top level
                level_next = (cfg.level > LEVEL_TOP) ? LEVEL_TOP : cfg.level;
            end
            if (cfg.ext_sel_we && st_reg == PUES_ON) begin
                ext_next = cfg.ext_sel;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_reg <= PUES_OFF;
            cnt_reg <= '0;
            in_low_reg <= 1'b0;
            blank_reg <= '0;
            level_reg <= LEVEL_RESET;
            ext_reg <= EXT_SEL_RESET;
        end else if (clk_en) begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            in_low_reg <= in_low_next;
            blank_reg <= blank_next;
            level_reg <= level_next;
            ext_reg <= ext_next;
        end
    end

    logic [MV_W-1:0] mv_val;
    assign mv_val = MV_W'(LEVEL_BASE_MV) + MV_W'(level_reg) * MV_W'(LEVEL_STEP_MV);
    assign input_undervoltage_level_mv = mv_val;

    // open-drain attention: drive low when powered
    assign attention_n_o = 1'b0;
    assign attention_n_oe = (st_reg == PUES_ON);
    assign converter_enable = (st_reg == PUES_ON) && !in_low_reg && conv_request;
    assign internal_regulator_on = (st_reg != PUES_OFF) && !ext_reg;
    assign phy_enable = FULL_VARIANT && (st_reg == PUES_ON);
    assign phy_reference_supply_on = FULL_VARIANT && (st_reg != PUES_OFF);
    assign status = '{powered: (st_reg == PUES_ON), conv_allow: !in_low_reg,
        in_low: in_low_reg, ext_supply: ext_reg, level: level_reg};

    // assertions
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (reset);

    attn_when_on_a: assert property (attention_n_oe |-> $past(en_s) && $past(fall_s))
        else $error("attention driven without enable and rail");
    conv_off_low_a: assert property (in_low_reg |-> !converter_enable)
        else $error("converter on during input lockout");
    level_range_a: assert property (level_reg <= LEVEL_TOP)
        else $error("lockout level code out of range");
    level_reset_a: assert property (clk_en && st_reg == PUES_OFF
        |=> level_reg == LEVEL_RESET && ext_reg == EXT_SEL_RESET)
        else $error("level not reset in off");
    blank_hold_a: assert property (clk_en && $rose(in_low_reg) |->
        blank_reg == '0 && $past(blank_reg) == BLANK_W'(BLANK_COUNT - 1))
        else $error("lockout without full blanking");
    off_low_en_a: assert property (clk_en && !en_s && st_reg != PUES_OFF
        |=> st_reg == PUES_OFF)
        else $error("no shutdown on enable low");
    start_cond_a: assert property (clk_en && st_reg == PUES_OFF && st_next == PUES_START
        |-> en_s && rise_s)
        else $error("start without rail and enable");
    ext_reg_a: assert property (ext_reg |-> !internal_regulator_on)
        else $error("regulator on with external select");
    resume_a: assert property (clk_en && st_reg == PUES_ON && inok_s
        |=> !in_low_reg || st_reg == PUES_OFF)
        else $error("no resume after input recovers");
    phy_var_a: assert property (!FULL_VARIANT |-> !phy_enable)
        else $error("phy on in pass-through variant");

    power_up_c: cover property (st_reg == PUES_START ##1 st_reg == PUES_ON);
    lockout_c: cover property ($rose(in_low_reg));
    resume_c: cover property ($fell(in_low_reg) && st_reg == PUES_ON);
    ext_c: cover property ($rose(ext_reg));
endmodule : pues_sequencer

//--- rtl/pues_pkg.sv
// pues_pkg: constants and carriers for the power-up enable sequencer.
// assumes a single 100 MHz core clock domain.
package pues_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // input lockout blanking interval in microseconds
    localparam int unsigned BLANK_US = 150;
    localparam int unsigned BLANK_CYC = (BLANK_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned BLANK_W = 16;
    // startup settling before completion is signalled, in ns
    localparam int unsigned START_NS = 1000;
    localparam int unsigned START_CYC = (START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LEVEL_W = 4;
    // lockout level code: 4.5V + 0.4V per step, in mV
    localparam int unsigned LEVEL_BASE_MV = 4500;
    localparam int unsigned LEVEL_STEP_MV = 400;
    localparam int unsigned LEVEL_MAX_MV = 8500;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h0;
    localparam logic [LEVEL_W-1:0] LEVEL_TOP = 4'hA;
    localparam logic EXT_SEL_RESET = 1'b0;
    localparam int unsigned MV_W = 16;

    typedef enum logic [1:0] {
        PUES_OFF = 2'b00,
        PUES_START = 2'b01,
        PUES_ON = 2'b10
    } pues_state_t;

    // host configuration carrier
    typedef struct packed {
        logic [LEVEL_W-1:0] level;
        logic level_we;
        logic ext_sel;
        logic ext_sel_we;
    } pues_cfg_t;

    // status carrier
    typedef struct packed {
        logic powered;
        logic conv_allow;
        logic in_low;
        logic ext_supply;
        logic [LEVEL_W-1:0] level;
    } pues_stat_t;
endpackage : pues_pkg

//--- rtl/pues_sync.sv
// pues_sync: three-stage synchroniser with agreement filter for pin levels.
// assumes asynchronous inputs; output changes when stages two and three agree.
`timescale 1ns/1ns
module pues_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clocking
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    // pins and result
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] lvl_reg;
    logic [WIDTH-1:0] lvl_next;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_comb begin
                lvl_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : lvl_reg[gi];
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            lvl_reg <= '0;
        end else if (clk_en) begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    assign level_out = lvl_reg;
endmodule : pues_sync

//--- verification/pues_host_model.sv
// pues_host_model: host controller side, issues level and supply-select writes.
// assumes it shares core_clk with the sequencer and drives at the falling edge.
`timescale 1ns/1ns
module pues_host_model (
    // clocking
    input wire logic core_clk,
    // device status
    input wire logic attention_n_oe,
    // configuration out
    output pues_pkg::pues_cfg_t cfg,
    output logic conv_request
);
    import pues_pkg::*;
    logic ext_applied;
    initial begin
        cfg = '0;
        conv_request = 1'b0;
        ext_applied = 1'b0;
    end
    task automatic write_level(input logic [LEVEL_W-1:0] code);
        if (attention_n_oe === 1'b1) begin
            @(negedge core_clk);
            cfg.level = code;
            cfg.level_we = 1'b1;
            @(negedge core_clk);
            cfg.level_we = 1'b0;
        end
    endtask : write_level
    // external rail goes up first, select follows only once power-up is done
    task automatic select_ext();
        ext_applied = 1'b1;
        if (attention_n_oe === 1'b1 && ext_applied) begin
            @(negedge core_clk);
            cfg.ext_sel = 1'b1;
            cfg.ext_sel_we = 1'b1;
            @(negedge core_clk);
            cfg.ext_sel_we = 1'b0;
        end
    endtask : select_ext
endmodule : pues_host_model

//--- verification/tb.sv
// tb: self-checking bench for the power-up enable sequencer.
// assumes short blanking and startup counts set through parameters.
`timescale 1ns/1ns
module tb;
    import pues_pkg::*;
    localparam int unsigned BLANK_T = 8;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic hv_en = 1'b0;
    logic rail_rise = 1'b0;
    logic rail_fall = 1'b0;
    logic in_ok = 1'b0;
    logic att_o, att_oe, conv_en, reg_on, phy_en, phy_sup;
    logic [MV_W-1:0] lvl_mv;
    pues_stat_t stat;
    pues_cfg_t cfg;
    logic conv_req;
    int fails = 0;
    int n_checks = 0;
    int i;
    always #5 core_clk = ~core_clk;
    pues_host_model pues_host_model_inst (.core_clk(core_clk), .attention_n_oe(att_oe),
        .cfg(cfg), .conv_request(conv_req));
    pues_sequencer #(.BLANK_COUNT(BLANK_T), .START_COUNT(4)) pues_sequencer_inst (
        .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
        .high_voltage_enable_pin(hv_en), .rail_above_rise(rail_rise),
        .rail_above_fall(rail_fall), .input_above_level(in_ok), .cfg(cfg),
        .conv_request(conv_req), .attention_n_o(att_o), .attention_n_oe(att_oe),
        .converter_enable(conv_en), .internal_regulator_on(reg_on), .phy_enable(phy_en),
        .phy_reference_supply_on(phy_sup), .input_undervoltage_level_mv(lvl_mv),
        .status(stat));
    task automatic chk(input bit ok, input string m);
        n_checks++;
        if (!ok) begin
            fails++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    task automatic wait_att(input logic want);
        for (i = 0; i < 60 && att_oe !== want; i++) @(negedge core_clk);
        chk(att_oe === want, "attention wait");
        if (att_oe !== want) give_verdict();
    endtask : wait_att
    task automatic t_power_up();
        chk(att_oe === 1'b0 && reg_on === 1'b0 && lvl_mv === 16'h1194, "reset");
        rail_rise = 1'b1;
        rail_fall = 1'b1;
        in_ok = 1'b1;
        repeat (20) @(negedge core_clk);
        chk(att_oe === 1'b0, "up without enable");
        hv_en = 1'b1;
        wait_att(1'b1);
        chk(att_o === 1'b0 && stat.powered === 1'b1, "done");
        chk(reg_on === 1'b1 && phy_en === 1'b1 && phy_sup === 1'b1, "phy");
    endtask : t_power_up
    task automatic t_levels();
        for (int c = 0; c < 16; c++) begin
            pues_host_model_inst.write_level(c[3:0]);
            chk(lvl_mv === MV_W'(c > 10 ? 8500 : 4500 + 400 * c), "level");
        end
        pues_host_model_inst.write_level(4'h0);
    endtask : t_levels
    task automatic t_blank();
        pues_host_model_inst.conv_request = 1'b1;
        @(negedge core_clk);
        chk(conv_en === 1'b1, "converter on");
        in_ok = 1'b0;
        repeat (4) @(negedge core_clk);
        in_ok = 1'b1;
        repeat (20) begin
            @(negedge core_clk);
            chk(conv_en === 1'b1, "glitch passed");
        end
        in_ok = 1'b0;
        for (i = 0; i < 60 && conv_en !== 1'b0; i++) @(negedge core_clk);
        chk(conv_en === 1'b0 && i >= BLANK_T && stat.in_low === 1'b1, "lockout");
        if (conv_en !== 1'b0) give_verdict();
        in_ok = 1'b1;
        for (i = 0; i < 20 && conv_en !== 1'b1; i++) @(negedge core_clk);
        chk(conv_en === 1'b1 && att_oe === 1'b1, "resume");
        if (conv_en !== 1'b1) give_verdict();
    endtask : t_blank
    task automatic t_ext();
        pues_host_model_inst.select_ext();
        chk(reg_on === 1'b0 && stat.ext_supply === 1'b1, "external");
    endtask : t_ext
    task automatic t_shutdown(input bit by_pin);
        if (by_pin) hv_en = 1'b0;
        else rail_fall = 1'b0;
        wait_att(1'b0);
        chk(conv_en === 1'b0 && reg_on === 1'b0 && phy_sup === 1'b0, "off");
        hv_en = 1'b1;
        rail_fall = 1'b1;
        wait_att(1'b1);
        chk(reg_on === 1'b1 && lvl_mv === 16'h1194, "defaults back");
    endtask : t_shutdown
    task automatic give_verdict();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        t_power_up();
        t_levels();
        t_blank();
        t_ext();
        t_shutdown(1'b0);
        t_ext();
        t_shutdown(1'b1);
        give_verdict();
    end
endmodule : tb
